// ==== design/ppic_top.sv ====
// file: port 0 pull-up enable and external irq edge configuration block
`timescale 1ns/1ps
module ppic_top
	import ppic_pkg::*;
(
	// clock and reset
	input  wire logic                clock,
	input  wire logic                rst,
	// register access
	input  wire ppic_reg_req_t       reg_req,
	input  wire logic                reg_rd,
	output logic [7:0]               reg_rdata,
	// pin modes from the port control registers
	input  wire logic [15:0]         pin_mode,
	// pins
	input  wire logic [NUM_IRQ-1:0]  irq_pin,
	// outputs
	output logic [NUM_PINS-1:0]      pullup_on,
	output logic [NUM_IRQ-1:0]       irq_req
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] port0_pullup_enable;
	logic [7:0] port0_ext_irq_edge_config;
	logic       hit_pullup;
	logic       hit_irq;

	// address decode, bank 1 only
	assign hit_pullup = (reg_req.bank == REG_BANK) && (reg_req.addr == ADDR_PULLUP);
	assign hit_irq    = (reg_req.bank == REG_BANK) && (reg_req.addr == ADDR_IRQ_CFG);

	always_ff @(posedge clock)
	begin
		if (rst)
			port0_pullup_enable <= RESET_PULLUP;
		else if (reg_req.wr && hit_pullup)
			port0_pullup_enable <= reg_req.wdata;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			port0_ext_irq_edge_config <= RESET_IRQ_CFG;
		else if (reg_req.wr && hit_irq)
			port0_ext_irq_edge_config <= reg_req.wdata;
	end

	// registered read data, unmapped reads give zero
	always_ff @(posedge clock)
	begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd && hit_pullup)
			reg_rdata <= port0_pullup_enable;
		else if (reg_rd && hit_irq)
			reg_rdata <= port0_ext_irq_edge_config;
		else
			reg_rdata <= 8'h00;
	end

	// ----------------------------------------------------------------
	// pull-up control
	// ----------------------------------------------------------------
	logic [NUM_PINS-1:0] next_pullup_on;

	always_comb
	begin
		for (int i = 0; i < NUM_PINS; i++)
		begin
			// only input mode keeps the enable
			next_pullup_on[i] = port0_pullup_enable[i] &&
				(pin_mode[i*FIELD_W +: FIELD_W] == PPIC_MODE_INPUT);
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			pullup_on <= '0;
		else
			pullup_on <= next_pullup_on;
	end

	// ----------------------------------------------------------------
	// external irq edge detectors
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_IRQ; g++)
		begin : g_irq
			ppic_edge_det u_det (
				.clock    (clock),
				.rst      (rst),
				.pin      (irq_pin[g]),
				.edge_cfg (port0_ext_irq_edge_config[g*FIELD_W +: FIELD_W]),
				.irq_req  (irq_req[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	AST_PULLUP_WRITE: assert property (@(posedge clock) disable iff (rst)
		reg_req.wr && hit_pullup |=> port0_pullup_enable == $past(reg_req.wdata))
		else $error("pull-up enable register did not take write");

	AST_IRQ_WRITE: assert property (@(posedge clock) disable iff (rst)
		reg_req.wr && hit_irq |=> port0_ext_irq_edge_config == $past(reg_req.wdata))
		else $error("irq config register did not take write");

	AST_PULLUP_BANK0: assert property (@(posedge clock) disable iff (rst)
		reg_req.wr && reg_req.bank != REG_BANK |=> $stable(port0_pullup_enable))
		else $error("pull-up register changed on bank 0 write");

	AST_PULLUP_INPUT: assert property (@(posedge clock) disable iff (rst)
		pin_mode[1:0] == PPIC_MODE_INPUT && port0_pullup_enable[0] |=> pullup_on[0])
		else $error("pull-up 0 not on in input mode");

	AST_PULLUP_PUSH: assert property (@(posedge clock) disable iff (rst)
		pin_mode[15:14] == PPIC_MODE_PUSH |=> !pullup_on[7])
		else $error("pull-up 7 on in push-pull mode");

	AST_PULLUP_ALT: assert property (@(posedge clock) disable iff (rst)
		pin_mode[3:2] == PPIC_MODE_ALT_A || pin_mode[3:2] == PPIC_MODE_ALT_B |=> !pullup_on[1])
		else $error("pull-up 1 on in alternative function mode");

	AST_IRQ_OFF: assert property (@(posedge clock) disable iff (rst)
		port0_ext_irq_edge_config[1:0] == PPIC_EDGE_OFF |=> !irq_req[0])
		else $error("irq 0 raised while disabled");

	AST_IRQ_PULSE: assert property (@(posedge clock) disable iff (rst)
		irq_req[2] && port0_ext_irq_edge_config[5:4] != PPIC_EDGE_BOTH |=> !irq_req[2])
		else $error("irq 2 request longer than one cycle");

	AST_IRQ_RISE: assert property (@(posedge clock) disable iff (rst)
		$rose(irq_req[3]) |-> $past(port0_ext_irq_edge_config[7:6]) != PPIC_EDGE_OFF)
		else $error("irq 3 raised by wrong field");

	// ----------------------------------------------------------------
	// register read-back and reset assertions
	// ----------------------------------------------------------------
	// read data shows the register as it stood at the strobe
	AST_RDATA_PULLUP: assert property (@(posedge clock) disable iff (rst)
		reg_rd && hit_pullup |=> reg_rdata == $past(port0_pullup_enable))
		else $error("pull-up enable register read back wrong");

	AST_RDATA_IRQ: assert property (@(posedge clock) disable iff (rst)
		reg_rd && hit_irq |=> reg_rdata == $past(port0_ext_irq_edge_config))
		else $error("irq config register read back wrong");

	// unmapped or bank 0 reads must not leak a register value
	AST_RDATA_ZERO: assert property (@(posedge clock) disable iff (rst)
		!(reg_rd && (hit_pullup || hit_irq)) |=> reg_rdata == 8'h00)
		else $error("read data not zero outside the mapped registers");

	// a register moves only on a write that hits it
	AST_PULLUP_HOLD: assert property (@(posedge clock) disable iff (rst)
		!(reg_req.wr && hit_pullup) |=> $stable(port0_pullup_enable))
		else $error("pull-up enable register changed without a write");

	AST_IRQ_HOLD: assert property (@(posedge clock) disable iff (rst)
		!(reg_req.wr && hit_irq) |=> $stable(port0_ext_irq_edge_config))
		else $error("irq config register changed without a write");

	// reset clears both registers and every output
	AST_PULLUP_RESET: assert property (@(posedge clock)
		rst |=> port0_pullup_enable == RESET_PULLUP && pullup_on == '0)
		else $error("pull-up state not cleared by reset");

	AST_IRQ_RESET: assert property (@(posedge clock)
		rst |=> port0_ext_irq_edge_config == RESET_IRQ_CFG && irq_req == '0)
		else $error("irq state not cleared by reset");

	AST_RDATA_RESET: assert property (@(posedge clock)
		rst |=> reg_rdata == 8'h00)
		else $error("read data not cleared by reset");

	// ----------------------------------------------------------------
	// per-pin pull-up and irq assertions
	// ----------------------------------------------------------------
	genvar p;
	generate
		for (p = 0; p < NUM_PINS; p++)
		begin : g_pin_chk
			AST_PIN_FORCED_OFF: assert property (@(posedge clock) disable iff (rst)
				pin_mode[p*FIELD_W +: FIELD_W] != PPIC_MODE_INPUT |=> !pullup_on[p])
				else $error("pull-up on in a mode that forces it off");

			AST_PIN_FOLLOWS: assert property (@(posedge clock) disable iff (rst)
				pin_mode[p*FIELD_W +: FIELD_W] == PPIC_MODE_INPUT
				|=> pullup_on[p] == $past(port0_pullup_enable[p]))
				else $error("pull-up does not follow its enable bit in input mode");
		end
	endgenerate

	genvar r;
	generate
		for (r = 0; r < NUM_IRQ; r++)
		begin : g_irq_chk
			AST_IRQ_FIELD_ON: assert property (@(posedge clock) disable iff (rst)
				irq_req[r] |-> $past(port0_ext_irq_edge_config[r*FIELD_W +: FIELD_W])
					!= PPIC_EDGE_OFF)
				else $error("irq request raised with its field disabled");

			// single-edge modes pulse once; a changed field may legally re-fire
			AST_IRQ_ONE_CYCLE: assert property (@(posedge clock) disable iff (rst)
				irq_req[r] && $stable(port0_ext_irq_edge_config[r*FIELD_W +: FIELD_W]) &&
				port0_ext_irq_edge_config[r*FIELD_W +: FIELD_W] != PPIC_EDGE_BOTH
				|=> !irq_req[r])
				else $error("irq request held longer than one cycle");
		end
	endgenerate

endmodule : ppic_top

// ==== design/ppic_pkg.sv ====
// package: register map, field layout and mode encodings for the port 0 pull-up and irq block
// Operation
// - each pin has its own pull-up enable bit; 1 turns pull-up on
// - pull-up forced off for push-pull output or alternative function modes
// - pull-up enable register sits at E2H in bank 1, read/write
// - external irq edge config register sits at E3H in bank 1, read/write
// - pins 0..3 each own a 2-bit field, pin n at bits 2n+1:2n
// - field 00 off, 01 falling, 10 rising, 11 either edge
// - pin mode is 2 bits per pin: 00 input, 01/10 alternate, 11 push-pull
package ppic_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic       REG_BANK        = 1'h1;
	localparam logic [7:0] ADDR_PULLUP     = 8'hE2;
	localparam logic [7:0] ADDR_IRQ_CFG    = 8'hE3;
	localparam logic [7:0] RESET_PULLUP    = 8'h00;
	localparam logic [7:0] RESET_IRQ_CFG   = 8'h00;
	localparam int         NUM_PINS        = 8;
	localparam int         NUM_IRQ         = 4;
	localparam int         FIELD_W         = 2;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PPIC_EDGE_OFF  = 2'h0,
		PPIC_EDGE_FALL = 2'h1,
		PPIC_EDGE_RISE = 2'h2,
		PPIC_EDGE_BOTH = 2'h3
	} ppic_edge_t;

	typedef enum logic [1:0] {
		PPIC_MODE_INPUT = 2'h0,
		PPIC_MODE_ALT_A = 2'h1,
		PPIC_MODE_ALT_B = 2'h2,
		PPIC_MODE_PUSH  = 2'h3
	} ppic_mode_t;

	// register access request from the cpu side
	typedef struct packed {
		logic       wr;
		logic       bank;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ppic_reg_req_t;

endpackage : ppic_pkg

// ==== design/ppic_edge_det.sv ====
// file: one external irq pin synchroniser and edge detector
`timescale 1ns/1ps
module ppic_edge_det
	import ppic_pkg::*;
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// pin and configuration
	input  wire logic       pin,
	input  wire logic [1:0] edge_cfg,
	// request pulse
	output logic            irq_req
);

	logic sync_a;
	logic sync_b;
	logic prev;
	logic rise;
	logic fall;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			sync_a <= 1'h0;
			sync_b <= 1'h0;
			prev   <= 1'h0;
		end
		else
		begin
			sync_a <= pin;
			sync_b <= sync_a;
			prev   <= sync_b;
		end
	end

	assign rise = sync_b & ~prev;
	assign fall = ~sync_b & prev;

	always_ff @(posedge clock)
	begin
		if (rst)
			irq_req <= 1'h0;
		else
		begin
			case (edge_cfg)
				PPIC_EDGE_FALL: irq_req <= fall;
				PPIC_EDGE_RISE: irq_req <= rise;
				PPIC_EDGE_BOTH: irq_req <= rise | fall;
				default:        irq_req <= 1'h0;
			endcase
		end
	end

	AST_DET_RISE: assert property (@(posedge clock) disable iff (rst)
		rise && (edge_cfg == PPIC_EDGE_RISE || edge_cfg == PPIC_EDGE_BOTH) |=> irq_req)
		else $error("selected rising edge gave no request");

	AST_DET_FALL: assert property (@(posedge clock) disable iff (rst)
		fall && (edge_cfg == PPIC_EDGE_FALL || edge_cfg == PPIC_EDGE_BOTH) |=> irq_req)
		else $error("selected falling edge gave no request");

	AST_DET_QUIET: assert property (@(posedge clock) disable iff (rst)
		!rise && !fall |=> !irq_req)
		else $error("request raised without a detected edge");

endmodule : ppic_edge_det

// ==== tb/ppic_pin_model.sv ====
// model: outside sources driving the irq-capable port 0 pins
`timescale 1ns/1ps
module ppic_pin_model
(
	// clock and wanted levels
	input  wire logic       clock,
	input  wire logic [3:0] level,
	// pins towards the block
	output logic      [3:0] irq_pin
);
	// pins start low and move well away from the sampling edge
	initial irq_pin = 4'h0;
	always @(posedge clock) irq_pin <= #30 level;
endmodule : ppic_pin_model

// ==== tb/ppic_top_tb.sv ====
// testbench: register, pull-up and irq edge checks for ppic_top
`timescale 1ns/1ps
module ppic_top_tb
	import ppic_pkg::*;
;
	logic          clock = 1'h0, rst = 1'h1, reg_rd = 1'h0, rd_seen = 1'h0;
	ppic_reg_req_t reg_req = '0;
	logic [15:0]   pin_mode = '0, pm;
	logic [3:0]    level = '0, irq_pin, irq_req;
	logic [7:0]    reg_rdata, pullup_on, v, pu;
	logic [1:0]    q;
	logic [7:0]    rd_q[$];
	logic [7:0]    cnt[4];
	int            n_errors = 0, total_checks = 0, seed = 32'h9928EE7B;

	// clock at 100 ns period
	always #50 clock = ~clock;

	ppic_top dut (.clock(clock), .rst(rst), .reg_req(reg_req), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pin_mode(pin_mode), .irq_pin(irq_pin),
		.pullup_on(pullup_on), .irq_req(irq_req));
	ppic_pin_model pins (.clock(clock), .level(level), .irq_pin(irq_pin));

	task automatic check(string name, logic [7:0] exp, logic [7:0] got);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	task automatic wr(logic b, logic [7:0] a, logic [7:0] d);
		@(posedge clock) reg_req <= '{1'h1, b, a, d};
		@(posedge clock) reg_req.wr <= 1'h0;
	endtask : wr

	// read request notes the expected data for the monitor
	task automatic rd(logic b, logic [7:0] a, logic [7:0] e);
		rd_q.push_back(e);
		@(posedge clock)
		begin
			reg_req <= '{1'h0, b, a, 8'h00};
			reg_rd <= 1'h1;
		end
		@(posedge clock) reg_rd <= 1'h0;
	endtask : rd

	function automatic logic [7:0] pu_mask(logic [15:0] m);
		for (int i = 0; i < 8; i++) pu_mask[i] = (m[2*i +: 2] == PPIC_MODE_INPUT);
	endfunction : pu_mask

	// monitor: read data is valid in the cycle after the strobe
	always @(posedge clock) rd_seen <= reg_rd;
	always @(negedge clock)
		if (rd_seen) check("reg_rdata", rd_q.pop_front(), reg_rdata);
	// irq pulses are counted where they are settled, away from the launching edge
	always @(negedge clock) for (int i = 0; i < 4; i++) cnt[i] += irq_req[i];

	// watchdog
	initial
	begin
		#400000;
		n_errors++;
		wrap_up();
	end

	initial
	begin
		repeat (5) @(posedge clock);
		rst <= 1'h0;
		rd(1'h1, ADDR_PULLUP, RESET_PULLUP);
		rd(1'h1, ADDR_IRQ_CFG, RESET_IRQ_CFG);
		for (int k = 0; k < 8; k++)
		begin
			v = $random(seed);
			pu = $random(seed);
			pm = $random(seed);
			wr(1'h1, ADDR_PULLUP, pu);
			wr(1'h1, ADDR_IRQ_CFG, v);
			wr(1'h0, ADDR_PULLUP, ~pu);
			wr(1'h0, ADDR_IRQ_CFG, ~v);
			wr(1'h1, 8'hE4, ~pu);
			rd(1'h1, ADDR_PULLUP, pu);
			rd(1'h1, ADDR_IRQ_CFG, v);
			rd(1'h1, 8'hE4, 8'h00);
			rd(1'h0, ADDR_PULLUP, 8'h00);
			@(posedge clock) pin_mode <= pm;
			repeat (2) @(posedge clock);
			@(negedge clock) check("pullup_on", pu & pu_mask(pm), pullup_on);
		end
		$display("register and pull-up test done");
		// mid-run reset must clear both registers and the pull-up outputs
		@(posedge clock) rst <= 1'h1;
		repeat (5) @(posedge clock);
		rst <= 1'h0;
		@(negedge clock) check("pullup_on", 8'h00, pullup_on);
		rd(1'h1, ADDR_PULLUP, RESET_PULLUP);
		rd(1'h1, ADDR_IRQ_CFG, RESET_IRQ_CFG);
		$display("reset test done");
		for (int c = 0; c < 4; c++)
		begin
			wr(1'h1, ADDR_IRQ_CFG, {2'(c + 3), 2'(c + 2), 2'(c + 1), 2'(c)});
			for (int e = 0; e < 2; e++)
			begin
				cnt = '{default: 0};
				@(posedge clock) level <= ~level;
				repeat (6) @(posedge clock);
				@(negedge clock);
				for (int i = 0; i < 4; i++)
				begin
					q = 2'(c + i);
					check("irq_req", 8'(q[1 - e]), cnt[i]);
				end
			end
		end
		$display("irq edge test done");
		wrap_up();
	end
endmodule : ppic_top_tb
